// ---- design/pms_pkg.sv ----
// Constants and types for the power mode sequencer
// What this block does
// [RL1] In stand-alone operation the chip turns on only after the mode pin has stayed high for more than 2 ms.
// [RL2] Under serial host control the chip powers up as soon as a bus start condition is seen.
// [RL3] In slider operation the chip turns off once the mode pin has stayed low for 10 ms.
// [RL4] In push-button operation a running chip turns off when the mode pin stays high for more than 2.4 s.
// [RL5] The chip powers down when the host clears the power-keep bit while the host-control bit is set.
// [RL6] The host must set the host-control bit before it clears the power-keep bit.
// [RL7] The chip shuts down whenever the negative rail rises above its off-threshold.
// [RL8] A qualified mode pin rise runs the fixed start-up sequence with no further action.
// [RL9] Two bits pick the control style: 00 button, 10 slider, 11 full slider, 01 unused.
// [RL10] In push-button operation a short press toggles monitor mode and a long press shuts down.
// [RL11] The mode pin is synchronised and its high and low times are counted before any decision.
package pms_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned ON_HOLD_US = 2000;
	localparam int unsigned OFF_LOW_US = 10000;
	localparam int unsigned LONG_PRESS_US = 2400000;
	localparam int unsigned STEP_US = 100;
	localparam int unsigned ON_HOLD_CYC = ON_HOLD_US * CLK_MHZ;
	localparam int unsigned OFF_LOW_CYC = OFF_LOW_US * CLK_MHZ;
	localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_US * CLK_MHZ;
	localparam int unsigned STEP_CYC = STEP_US * CLK_MHZ;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned SEQ_STEPS = 4;
	localparam logic [1:0] STYLE_BUTTON = 2'h0;
	localparam logic [1:0] STYLE_UNUSED = 2'h1;
	localparam logic [1:0] STYLE_SLIDER = 2'h2;
	localparam logic [1:0] STYLE_FULL = 2'h3;
	localparam logic [2:0] STEP_ALL = 3'h4;
	typedef enum logic [1:0] {
		PMS_OFF = 2'b00,
		PMS_START = 2'b01,
		PMS_RUN = 2'b10
	} pms_state_e;
endpackage : pms_pkg

// ---- design/pms_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pms_sync (
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin,
	output logic level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_d;
	// Only the second and third stages are compared; the first may be metastable
	assign level_d = (s2_q == s3_q) ? s3_q : level;
	always_ff @(posedge clock) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level <= level_d;
		end
	end
endmodule : pms_sync

// ---- design/pms_sequencer.sv ----
// Power mode sequencer top
`timescale 1ns/1ps
module pms_sequencer #(
	parameter int unsigned ON_HOLD_CYCLES = pms_pkg::ON_HOLD_CYC,
	parameter int unsigned OFF_LOW_CYCLES = pms_pkg::OFF_LOW_CYC,
	parameter int unsigned LONG_PRESS_CYCLES = pms_pkg::LONG_PRESS_CYC,
	parameter int unsigned STEP_CYCLES = pms_pkg::STEP_CYC
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic mode_pin,
	input wire logic host_mode,
	input wire logic bus_start,
	input wire logic power_keep_bit,
	input wire logic host_control_bit,
	input wire logic charge_pump_overcurrent,
	input wire logic slide_switch_power_select,
	input wire logic slide_switch_monitor_select,
	output logic chip_on,
	output logic startup_busy,
	output logic [2:0] startup_step,
	output logic monitor_mode,
	output logic style_invalid
);
	pms_pkg::pms_state_e state_q;
	pms_pkg::pms_state_e state_d;
	logic mode_lvl;
	logic mode_prev_q;
	logic [pms_pkg::CNT_W-1:0] high_cnt_q;
	logic [pms_pkg::CNT_W-1:0] low_cnt_q;
	logic [pms_pkg::CNT_W-1:0] step_cnt_q;
	logic [2:0] step_q;
	logic [2:0] step_out;
	logic [pms_pkg::CNT_W-1:0] busy_len_q;
	logic [1:0] style;
	logic style_bad;
	logic is_button;
	logic is_slider;
	logic qual_on;
	logic qual_off_low;
	logic qual_long;
	logic short_release;
	logic power_up_req;
	logic power_down_req;
	logic host_off;
	logic step_done;
	logic fault_lvl;
	logic long_seen_q;
	localparam int unsigned SEQ_STEPS_CHK = pms_pkg::SEQ_STEPS * STEP_CYCLES;

	pms_sync u_mode_sync (
		.clock(clock),
		.nrst(nrst),
		.pin(mode_pin),
		.level(mode_lvl)
	);
	pms_sync u_fault_sync (
		.clock(clock),
		.nrst(nrst),
		.pin(charge_pump_overcurrent),
		.level(fault_lvl)
	);

	assign style = {slide_switch_power_select, slide_switch_monitor_select}; // [RL9]
	assign is_button = (style == pms_pkg::STYLE_BUTTON); // [RL9]
	assign is_slider = (style == pms_pkg::STYLE_SLIDER) || (style == pms_pkg::STYLE_FULL); // [RL9]
	assign style_bad = (style == pms_pkg::STYLE_UNUSED); // [RL9]
	// Counters saturate so a held level cannot wrap into a false decision
	assign qual_on = mode_lvl && (high_cnt_q > ON_HOLD_CYCLES); // [RL1] [RL11]
	assign qual_off_low = !mode_lvl && (low_cnt_q >= OFF_LOW_CYCLES); // [RL3] [RL11]
	assign qual_long = mode_lvl && (high_cnt_q > LONG_PRESS_CYCLES); // [RL4] [RL11]
	assign short_release = mode_prev_q && !mode_lvl && !long_seen_q; // [RL10]
	assign host_off = host_mode && host_control_bit && !power_keep_bit; // [RL5] [RL6]
	// A held press must be released first, else a long-press shutdown restarts at once
	assign power_up_req = host_mode ? bus_start : (qual_on && !style_bad && !long_seen_q); // [RL1] [RL2] [RL8]
	assign power_down_req = fault_lvl || host_off
		|| (!host_mode && is_slider && qual_off_low)
		|| (!host_mode && is_button && qual_long); // [RL3] [RL4] [RL7] [RL10]
	assign step_done = (step_cnt_q >= STEP_CYCLES - 1);
	assign step_out = (state_d == pms_pkg::PMS_RUN) ? pms_pkg::STEP_ALL : step_q; // [RL8]

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			pms_pkg::PMS_OFF: begin
				if (power_up_req && !fault_lvl) begin
					state_d = pms_pkg::PMS_START; // [RL8]
				end
			end
			pms_pkg::PMS_START: begin
				if (power_down_req) begin
					state_d = pms_pkg::PMS_OFF; // [RL7]
				end else if (step_done && step_q == pms_pkg::STEP_ALL - 3'h1) begin
					state_d = pms_pkg::PMS_RUN; // [RL8]
				end
			end
			pms_pkg::PMS_RUN: begin
				if (power_down_req) begin
					state_d = pms_pkg::PMS_OFF; // [RL3] [RL4] [RL5] [RL7]
				end
			end
			default: state_d = pms_pkg::PMS_OFF;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			high_cnt_q <= '0;
			low_cnt_q <= '0;
			mode_prev_q <= 1'b0;
		end else begin
			mode_prev_q <= mode_lvl;
			if (mode_lvl) begin
				low_cnt_q <= '0;
				if (~&high_cnt_q) high_cnt_q <= high_cnt_q + 1'b1; // [RL11]
			end else begin
				high_cnt_q <= '0;
				if (~&low_cnt_q) low_cnt_q <= low_cnt_q + 1'b1; // [RL11]
			end
		end
	end

	// Long press seen flag keeps its release from counting as a short press
	always_ff @(posedge clock) begin
		if (!nrst) begin
			long_seen_q <= 1'b0;
		end else if (!mode_lvl && !mode_prev_q) begin
			long_seen_q <= 1'b0;
		end else if (qual_on && state_q != pms_pkg::PMS_RUN) begin
			long_seen_q <= 1'b1; // Power-up press is not a toggle
		end else if (qual_long) begin
			long_seen_q <= 1'b1; // [RL10]
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_q <= pms_pkg::PMS_OFF;
			step_q <= '0;
			step_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			if (state_q == pms_pkg::PMS_START && state_d == pms_pkg::PMS_START) begin
				if (step_done) begin
					step_cnt_q <= '0;
					step_q <= step_q + 3'h1; // [RL8]
				end else begin
					step_cnt_q <= step_cnt_q + 1'b1;
				end
			end else begin
				step_cnt_q <= '0;
				step_q <= (state_d == pms_pkg::PMS_RUN) ? pms_pkg::STEP_ALL : 3'h0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			chip_on <= 1'b0;
			startup_busy <= 1'b0;
			startup_step <= '0;
			monitor_mode <= 1'b0;
			style_invalid <= 1'b0;
		end else begin
			chip_on <= (state_d != pms_pkg::PMS_OFF);
			startup_busy <= (state_d == pms_pkg::PMS_START);
			startup_step <= (state_d == pms_pkg::PMS_OFF) ? 3'h0 : step_out;
			style_invalid <= style_bad; // [RL9]
			if (state_d != pms_pkg::PMS_RUN) begin
				monitor_mode <= 1'b0;
			end else if (is_button && !host_mode && short_release && state_q == pms_pkg::PMS_RUN) begin
				monitor_mode <= !monitor_mode; // [RL10]
			end
		end
	end

	// Helper count of start-up cycles for the length check
	always_ff @(posedge clock) begin
		if (!nrst) begin
			busy_len_q <= '0;
		end else if (startup_busy) begin
			busy_len_q <= busy_len_q + 1'b1;
		end else begin
			busy_len_q <= '0;
		end
	end

	a_fault_off: assert property (@(posedge clock) disable iff (!nrst)
		fault_lvl |=> !chip_on) else $error("chip on during rail fault"); // [RL7]
	a_host_off: assert property (@(posedge clock) disable iff (!nrst)
		(host_mode && host_control_bit && !power_keep_bit) |=> !chip_on) else $error("host power down ignored"); // [RL5]
	a_on_qualified: assert property (@(posedge clock) disable iff (!nrst)
		($rose(chip_on) && !host_mode) |-> $past(high_cnt_q) > ON_HOLD_CYCLES) else $error("early power up"); // [RL1]
	a_bus_start: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == pms_pkg::PMS_OFF && host_mode && bus_start && !fault_lvl) |=> chip_on) else $error("start missed"); // [RL2]
	a_slider_off: assert property (@(posedge clock) disable iff (!nrst)
		(!host_mode && is_slider && qual_off_low) |=> !chip_on) else $error("slider off missed"); // [RL3]
	a_long_press: assert property (@(posedge clock) disable iff (!nrst)
		(!host_mode && is_button && qual_long) |=> !chip_on) else $error("long press off missed"); // [RL4]
	a_seq_busy: assert property (@(posedge clock) disable iff (!nrst)
		$rose(startup_busy) |-> startup_step == 3'h0 ##1 (startup_busy || !chip_on)) else $error("sequence cut short"); // [RL8]
	a_style_bad: assert property (@(posedge clock) disable iff (!nrst)
		(style == pms_pkg::STYLE_UNUSED && !host_mode && !chip_on) |=> !chip_on) else $error("unused style"); // [RL9]
	a_mon_run: assert property (@(posedge clock) disable iff (!nrst)
		monitor_mode |-> chip_on && !startup_busy) else $error("monitor while not running"); // [RL10]
	a_sync_level: assert property (@(posedge clock) disable iff (!nrst)
		$changed(high_cnt_q) && high_cnt_q != 0 |-> $past(mode_lvl)) else $error("count while low"); // [RL11]

	a_seq_length: assert property (@(posedge clock) disable iff (!nrst)
		($fell(startup_busy) && chip_on) |-> busy_len_q == SEQ_STEPS_CHK) else $error("start-up length"); // [RL8]
	a_run_step: assert property (@(posedge clock) disable iff (!nrst)
		(chip_on && !startup_busy) |-> startup_step == pms_pkg::STEP_ALL) else $error("running step"); // [RL8]
	a_off_quiet: assert property (@(posedge clock) disable iff (!nrst)
		!chip_on |-> !startup_busy && startup_step == 3'h0 && !monitor_mode) else $error("outputs while off"); // [RL8]
	a_host_pin: assert property (@(posedge clock) disable iff (!nrst)
		(state_q == pms_pkg::PMS_OFF && host_mode && !bus_start) |=> !chip_on) else $error("host up without start"); // [RL2]
	a_style_flag: assert property (@(posedge clock) disable iff (!nrst)
		style_bad |=> style_invalid) else $error("unused style not flagged"); // [RL9]
	a_mon_toggle: assert property (@(posedge clock) disable iff (!nrst)
		$rose(monitor_mode) |-> $past(is_button && !host_mode)) else $error("monitor outside button"); // [RL10]
	a_slider_hold: assert property (@(posedge clock) disable iff (!nrst)
		(!host_mode && is_slider && chip_on && low_cnt_q < OFF_LOW_CYCLES && !fault_lvl) |=> chip_on) else $error("early slider off"); // [RL3]
endmodule : pms_sequencer

// ---- testbench/pms_partner.sv ----
// Model of the switches, push button and serial host
`timescale 1ns/1ps
module pms_partner (
	input wire logic clock,
	output logic mode_pin,
	output logic host_mode,
	output logic bus_start,
	output logic power_keep_bit,
	output logic host_control_bit,
	output logic charge_pump_overcurrent,
	output logic slide_switch_power_select,
	output logic slide_switch_monitor_select
);
	initial begin
		{mode_pin, host_mode, bus_start, host_control_bit, charge_pump_overcurrent} = 5'h00;
		{power_keep_bit, slide_switch_power_select, slide_switch_monitor_select} = 3'h4;
	end
	// Pin level held for whole cycles; callers pick press lengths
	task automatic drive_pin(input logic level, input int cycles);
		mode_pin = level;
		repeat (cycles) @(negedge clock);
	endtask : drive_pin
	task automatic set_cfg(input logic host, input logic [1:0] style, input logic fault);
		host_mode = host;
		{slide_switch_power_select, slide_switch_monitor_select} = style;
		charge_pump_overcurrent = fault;
		{power_keep_bit, host_control_bit} = 2'h2;
		@(negedge clock);
	endtask : set_cfg
	task automatic host_start();
		bus_start = 1'b1;
		@(negedge clock);
		bus_start = 1'b0;
	endtask : host_start
	// Select bit first, keep bit a cycle later, never the other way round
	task automatic host_release();
		host_control_bit = 1'b1;
		@(negedge clock);
		power_keep_bit = 1'b0;
		@(negedge clock);
	endtask : host_release
endmodule : pms_partner

// ---- testbench/power_mode_sequencer_bench.sv ----
// Self-checking bench for the power mode sequencer
`timescale 1ns/1ps
module power_mode_sequencer_bench;
	logic clock, nrst, mode_pin, host_mode, bus_start, power_keep_bit, host_control_bit;
	logic charge_pump_overcurrent, slide_switch_power_select, slide_switch_monitor_select;
	logic chip_on, startup_busy, monitor_mode, style_invalid;
	logic [2:0] startup_step;
	int err_count = 0;
	int checks_done = 0;
	pms_sequencer #(.ON_HOLD_CYCLES(20), .OFF_LOW_CYCLES(50), .LONG_PRESS_CYCLES(100), .STEP_CYCLES(4)) i_dut (
		.clock(clock), .nrst(nrst), .mode_pin(mode_pin), .host_mode(host_mode), .bus_start(bus_start),
		.power_keep_bit(power_keep_bit), .host_control_bit(host_control_bit),
		.charge_pump_overcurrent(charge_pump_overcurrent), .slide_switch_power_select(slide_switch_power_select),
		.slide_switch_monitor_select(slide_switch_monitor_select), .chip_on(chip_on),
		.startup_busy(startup_busy), .startup_step(startup_step), .monitor_mode(monitor_mode),
		.style_invalid(style_invalid));
	pms_partner i_far (.clock(clock), .mode_pin(mode_pin), .host_mode(host_mode), .bus_start(bus_start),
		.power_keep_bit(power_keep_bit), .host_control_bit(host_control_bit),
		.charge_pump_overcurrent(charge_pump_overcurrent), .slide_switch_power_select(slide_switch_power_select),
		.slide_switch_monitor_select(slide_switch_monitor_select));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check
	// Bounded wait, so a missing transition fails instead of hanging
	task automatic wait_on(input logic exp, input int lim);
		int n;
		n = 0;
		while (chip_on !== exp && n < lim) begin
			@(negedge clock);
			n++;
		end
		check({2'h0, chip_on}, {2'h0, exp}, "chip_on");
	endtask : wait_on
	task automatic stop_test();
		$display("mismatches %0d, checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	task automatic host_cycle();
		i_far.set_cfg(1'b1, 2'h2, 1'b0);
		i_far.host_start();
		@(negedge clock);
		check({chip_on, startup_busy, 1'b0}, 3'h6, "start-up entry");
		check(startup_step, 3'h0, "first step");
		repeat (4) @(negedge clock);
		check(startup_step, 3'h1, "second step");
		repeat (14) @(negedge clock);
		check({chip_on, startup_busy, 1'b0}, 3'h4, "start-up done");
		check(startup_step, 3'h4, "running step");
		i_far.host_release();
		check({2'h0, chip_on}, 3'h0, "host power down");
	endtask : host_cycle
	task automatic button_cycle();
		i_far.set_cfg(1'b0, 2'h0, 1'b0);
		i_far.drive_pin(1'b1, 15);
		i_far.drive_pin(1'b0, 30);
		check({2'h0, chip_on}, 3'h0, "short hold powered up");
		i_far.drive_pin(1'b1, 30);
		wait_on(1'b1, 10);
		i_far.drive_pin(1'b0, 30);
		check({2'h0, monitor_mode}, 3'h0, "power press toggled");
		i_far.drive_pin(1'b1, 10);
		i_far.drive_pin(1'b0, 10);
		check({2'h0, monitor_mode}, 3'h1, "monitor on");
		i_far.drive_pin(1'b1, 10);
		i_far.drive_pin(1'b0, 10);
		check({1'b0, monitor_mode, chip_on}, 3'h1, "monitor off");
		i_far.drive_pin(1'b1, 90);
		check({2'h0, chip_on}, 3'h1, "off before long press");
		i_far.drive_pin(1'b1, 30);
		wait_on(1'b0, 5);
		i_far.drive_pin(1'b1, 21);
		check({2'h0, chip_on}, 3'h0, "restart while held");
		i_far.drive_pin(1'b0, 30);
	endtask : button_cycle
	task automatic slider_cycle(input logic [1:0] style);
		i_far.set_cfg(1'b0, style, 1'b0);
		i_far.drive_pin(1'b1, 40);
		wait_on(1'b1, 5);
		i_far.drive_pin(1'b0, 40);
		i_far.drive_pin(1'b1, 10);
		check({2'h0, chip_on}, 3'h1, "short low turned off");
		i_far.drive_pin(1'b0, 50);
		wait_on(1'b0, 10);
	endtask : slider_cycle
	task automatic fault_and_style();
		i_far.set_cfg(1'b1, 2'h2, 1'b0);
		i_far.host_start();
		repeat (30) @(negedge clock);
		i_far.set_cfg(1'b1, 2'h2, 1'b1);
		wait_on(1'b0, 8);
		i_far.host_start();
		repeat (3) @(negedge clock);
		check({2'h0, chip_on}, 3'h0, "up during fault");
		i_far.set_cfg(1'b0, 2'h1, 1'b0);
		i_far.drive_pin(1'b1, 40);
		check({1'b0, chip_on, style_invalid}, 3'h1, "unused style");
		i_far.drive_pin(1'b0, 10);
	endtask : fault_and_style
	initial begin
		nrst = 1'b0;
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		@(negedge clock);
		check({chip_on, startup_busy, monitor_mode}, 3'h0, "reset outputs");
		host_cycle();
		button_cycle();
		slider_cycle(2'h3);
		slider_cycle(2'h2);
		fault_and_style();
		stop_test();
	end
	initial begin
		repeat (20000) @(negedge clock);
		err_count++;
		stop_test();
	end
endmodule : power_mode_sequencer_bench
